// *** rtl/fsp_device.sv ***
// converter end of the framed serial port
// Contract
// - standby low halts port and result logic
// - control bits switch both excitation currents
// - host lowers transmit frame before writing
// - self clocking starts after transmit frame falls
// - external clocking: frame low before bit
// - host lowers receive frame to read
// - self clocking: clock and data after frame
// - external clocking: data after receive frame
// - new result pulls data ready low
// - full result word sent returns data ready high
// - calibration finish also pulls data ready
// - result read drives data only if ready
// - write data sampled on rising clock edges
// - unipolar natural, bipolar offset binary coding
// - writes control/calibration; reads all three
// - mode pin high means device sources clock
// - select low control, high data/calibration
// - own clock released on frame end/word done
// - load only on 24 bits, extras ignored
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "fsp_regs.svh"
module fsp_device (
	input  wire logic           pclk,
	input  wire logic           presetn,
	input  wire logic [23:0]    sample_in,
	input  wire logic           sample_valid,
	input  wire logic           cal_done,
	output logic [23:0]         control_word,
	output logic [23:0]         calib_word,
	output logic                excitation_current_1,
	output logic                excitation_current_2,
	output logic                powered_down,
	fsp_if.device               link
);
	fsp_pkg::dev_state_t q;
	fsp_pkg::dev_state_t d;
	logic                rise;
	logic                fall;
	logic                last;

	// ==========================================================
	// result coding
	// result coding
	function automatic fsp_pkg::word_t code_sample(
		input logic [23:0] s,
		input logic        uni
	);
		if (!uni)
			return s ^ 24'h800000;
		else if (s[23])
			return 24'h000000;
		else
			return {s[22:0], 1'b0};
	endfunction : code_sample

	// ==========================================================
	// next state
	always_comb begin
		d = q;
		rise = 1'b0;
		fall = 1'b0;
		d.sclk_s1 = link.sclk;
		d.sclk_s2 = q.sclk_s1;
		d.sclk_d  = q.sclk_s2;
		d.sd_s1   = link.serial_data_line;
		d.sd_s2   = q.sd_s1;
		d.tfs_s1  = link.transmit_frame_n;
		d.tfs_s2  = q.tfs_s1;
		d.rfs_s1  = link.receive_frame_n;
		d.rfs_s2  = q.rfs_s1;
		d.mode_s1 = link.mode;
		d.mode_s2 = q.mode_s1;
		d.sel_s1  = link.register_select;
		d.sel_s2  = q.sel_s1;
		d.stby_s1 = link.standby_n;
		d.stby_s2 = q.stby_s1;
		last = (q.cnt == 5'(`FSP_WORD_BITS - 1));
		if (q.mode_s2) begin
			if (q.sclk_oe) begin
				d.div = q.div + 4'h1;
				if (q.div == 4'(`FSP_SCLK_HALF_CYC - 1)) begin
					d.div = 4'h0;
					d.sclk_o = !q.sclk_o;
					rise = !q.sclk_o;
					fall = q.sclk_o;
				end
			end
		end else begin
			rise = q.sclk_s2 & !q.sclk_d;
			fall = !q.sclk_s2 & q.sclk_d;
		end
		case (q.phase)
			fsp_pkg::PH_IDLE: begin
				d.cnt = 5'h00;
				d.div = 4'h0;
				d.sclk_o = 1'b1;
				d.sclk_oe = 1'b0;
				d.serial_data_line_oe = 1'b0;
				if (!q.tfs_s2) begin
					d.phase = fsp_pkg::PH_WRITE;
					d.sel = q.sel_s2;
					d.sclk_oe = q.mode_s2;
				end else if (!q.rfs_s2) begin
					d.phase = fsp_pkg::PH_READ;
					d.sel = q.sel_s2;
					d.data_rd = q.sel_s2 &&
						q.ctrl[`FSP_CTRL_MD_HI:`FSP_CTRL_MD_LO] == 3'h0;
					if (!q.sel_s2)
						d.shreg = q.ctrl;
					else if (d.data_rd)
						d.shreg = q.result;
					else
						d.shreg = q.cal;
					d.serial_data_line_o = d.shreg[`FSP_WORD_BITS-1];
					d.sclk_oe = q.mode_s2;
					d.serial_data_line_oe = !(d.data_rd && q.data_ready_n_n);
				end
			end
			fsp_pkg::PH_WRITE: begin
				if (q.tfs_s2) begin
					d.phase = fsp_pkg::PH_IDLE;
					d.sclk_oe = 1'b0;
				end else if (rise) begin
					d.shreg = {q.shreg[`FSP_WORD_BITS-2:0], q.sd_s2};
					d.cnt = q.cnt + 5'h01;
					if (last) begin
						if (q.sel)
							d.cal = d.shreg;
						else
							d.ctrl = d.shreg;
						d.phase = fsp_pkg::PH_DONE;
						d.sclk_oe = 1'b0;
					end
				end
			end
			fsp_pkg::PH_READ: begin
				if (q.rfs_s2) begin
					d.phase = fsp_pkg::PH_IDLE;
					d.sclk_oe = 1'b0;
					d.serial_data_line_oe = 1'b0;
				end else if (rise) begin
					d.cnt = q.cnt + 5'h01;
					if (last) begin
						d.phase = fsp_pkg::PH_DONE;
						d.sclk_oe = 1'b0;
						if (q.data_rd)
							d.data_ready_n_n = 1'b1;
					end
				end else if (fall && q.cnt != 5'h00) begin
					d.shreg = {q.shreg[`FSP_WORD_BITS-2:0], 1'b0};
					d.serial_data_line_o = q.shreg[`FSP_WORD_BITS-2];
				end
			end
			default: begin
				if (q.tfs_s2 && q.rfs_s2) begin
					d.phase = fsp_pkg::PH_IDLE;
					d.serial_data_line_oe = 1'b0;
				end
			end
		endcase
		d.pd = !q.stby_s2;
		if (!q.stby_s2) begin
			d.phase = fsp_pkg::PH_IDLE;
			d.sclk_oe = 1'b0;
			d.serial_data_line_oe = 1'b0;
			d.data_ready_n_n = 1'b1;
		end else begin
			if (sample_valid) begin
				d.result = code_sample(sample_in,
					q.ctrl[`FSP_CTRL_UNI_BIT]);
				d.data_ready_n_n = 1'b0;
			end
			if (cal_done)
				d.data_ready_n_n = 1'b0;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.sclk_s1 <= 1'b1;
			q.sclk_s2 <= 1'b1;
			q.sclk_d  <= 1'b1;
			q.tfs_s1  <= 1'b1;
			q.tfs_s2  <= 1'b1;
			q.rfs_s1  <= 1'b1;
			q.rfs_s2  <= 1'b1;
			q.stby_s1 <= 1'b1;
			q.stby_s2 <= 1'b1;
			q.ctrl    <= `FSP_CTRL_RESET;
			q.sclk_o  <= 1'b1;
			q.serial_data_line_o <= 1'b1;
			q.data_ready_n_n  <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// outputs
	assign link.dev_sclk_o   = q.sclk_o;
	assign link.dev_sclk_oe  = q.sclk_oe;
	assign link.dev_serial_data_line_o  = q.serial_data_line_o;
	assign link.dev_serial_data_line_oe = q.serial_data_line_oe;
	assign link.data_ready_n = q.data_ready_n_n;
	assign control_word      = q.ctrl;
	assign calib_word        = q.cal;
	assign excitation_current_1 = q.ctrl[`FSP_CTRL_EXC1_BIT];
	assign excitation_current_2 = q.ctrl[`FSP_CTRL_EXC2_BIT];
	assign powered_down      = q.pd;
endmodule : fsp_device

// *** rtl/fsp_host.sv ***
// host end of the framed serial port with an apb register slave
`timescale 1ns/1ps
`include "fsp_regs.svh"
module fsp_host (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	fsp_if.host              link
);
	fsp_pkg::host_state_t q;
	fsp_pkg::host_state_t d;
	logic                 rise;
	logic                 fall;
	logic                 last;
	logic                 acc;

	// ==========================================================
	// next state
	always_comb begin
		d = q;
		rise = 1'b0;
		fall = 1'b0;
		d.sclk_s1 = link.sclk;
		d.sclk_s2 = q.sclk_s1;
		d.sclk_d  = q.sclk_s2;
		d.sd_s1   = link.serial_data_line;
		d.sd_s2   = q.sd_s1;
		d.data_ready_n_s1 = link.data_ready_n;
		d.data_ready_n_s2 = q.data_ready_n_s1;
		last = (q.cnt == 5'(`FSP_WORD_BITS - 1));
		acc = psel & penable;
		if (!q.mode) begin
			if (q.sclk_oe) begin
				d.div = q.div + 4'h1;
				if (q.div == 4'(`FSP_SCLK_HALF_CYC - 1)) begin
					d.div = 4'h0;
					d.sclk_o = !q.sclk_o;
					rise = !q.sclk_o;
					fall = q.sclk_o;
				end
			end
		end else begin
			rise = q.sclk_s2 & !q.sclk_d;
			fall = !q.sclk_s2 & q.sclk_d;
		end
		case (q.phase)
			fsp_pkg::PH_IDLE: begin
				d.cnt = 5'h00;
				d.div = 4'h0;
				d.sclk_o = 1'b1;
			end
			fsp_pkg::PH_WRITE, fsp_pkg::PH_READ: begin
				if (rise) begin
					d.shreg = {q.shreg[`FSP_WORD_BITS-2:0], q.sd_s2};
					d.cnt = q.cnt + 5'h01;
					if (last) begin
						if (q.rd)
							d.rxdata = d.shreg;
						d.phase = fsp_pkg::PH_DONE;
					end
				end else if (fall && q.cnt != 5'h00 && !q.rd) begin
					// write data on fall
					// shift already done at the rise
					d.serial_data_line_o = q.shreg[`FSP_WORD_BITS-1];
				end
			end
			default: begin
				d.phase = fsp_pkg::PH_IDLE;
				d.tfs_n = 1'b1;
				d.rfs_n = 1'b1;
				d.sclk_oe = 1'b0;
				d.serial_data_line_oe = 1'b0;
			end
		endcase
		// apb: answer one cycle into the access phase
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		if (acc && !q.pready) begin
			d.pready = 1'b1;
			d.prdata = 32'h00000000;
			if (paddr == `FSP_OFF_CMD)
				d.prdata = {29'h0, q.sel, q.rd, 1'b0};
			else if (paddr == `FSP_OFF_TXDATA)
				d.prdata = {8'h00, q.txdata};
			else if (paddr == `FSP_OFF_RXDATA)
				d.prdata = {8'h00, q.rxdata};
			else if (paddr == `FSP_OFF_STATUS)
				d.prdata = {30'h0, !q.data_ready_n_s2,
					q.phase != fsp_pkg::PH_IDLE};
			else if (paddr == `FSP_OFF_CFG)
				d.prdata = {30'h0, q.stby_n, q.mode};
			else
				d.pslverr = 1'b1;
		end
		if (acc && q.pready && pwrite) begin
			if (paddr == `FSP_OFF_TXDATA)
				d.txdata = pwdata[`FSP_WORD_BITS-1:0];
			else if (paddr == `FSP_OFF_CFG &&
				q.phase == fsp_pkg::PH_IDLE) begin
				d.mode = pwdata[`FSP_CFG_MODE_BIT];
				d.stby_n = pwdata[`FSP_CFG_STBY_BIT];
			end else if (paddr == `FSP_OFF_CMD &&
				pwdata[`FSP_CMD_START_BIT] &&
				q.phase == fsp_pkg::PH_IDLE) begin
				d.rd = pwdata[`FSP_CMD_READ_BIT];
				d.sel = pwdata[`FSP_CMD_SEL_BIT];
				d.sclk_oe = !q.mode;
				if (pwdata[`FSP_CMD_READ_BIT]) begin
					d.phase = fsp_pkg::PH_READ;
					d.rfs_n = 1'b0;
				end else begin
					d.phase = fsp_pkg::PH_WRITE;
					d.tfs_n = 1'b0;
					d.shreg = q.txdata;
					d.serial_data_line_o = q.txdata[`FSP_WORD_BITS-1];
					d.serial_data_line_oe = 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.sclk_s1 <= 1'b1;
			q.sclk_s2 <= 1'b1;
			q.sclk_d  <= 1'b1;
			q.data_ready_n_s1 <= 1'b1;
			q.data_ready_n_s2 <= 1'b1;
			q.mode    <= 1'(`FSP_CFG_RESET >> `FSP_CFG_MODE_BIT);
			q.stby_n  <= 1'b1;
			q.sclk_o  <= 1'b1;
			q.serial_data_line_o <= 1'b1;
			q.tfs_n   <= 1'b1;
			q.rfs_n   <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// outputs
	assign prdata                 = q.prdata;
	assign pready                 = q.pready;
	assign pslverr                = q.pslverr;
	assign link.mode              = q.mode;
	assign link.standby_n         = q.stby_n;
	assign link.register_select   = q.sel;
	assign link.transmit_frame_n  = q.tfs_n;
	assign link.receive_frame_n   = q.rfs_n;
	assign link.host_sclk_o       = q.sclk_o;
	assign link.host_sclk_oe      = q.sclk_oe;
	assign link.host_serial_data_line_o      = q.serial_data_line_o;
	assign link.host_serial_data_line_oe     = q.serial_data_line_oe;
endmodule : fsp_host

// *** rtl/fsp_if.sv ***
// serial link between the converter port and its host
`timescale 1ns/1ps
interface fsp_if;
	logic mode;
	logic standby_n;
	logic register_select;
	logic transmit_frame_n;
	logic receive_frame_n;
	logic data_ready_n;
	logic dev_sclk_o, dev_sclk_oe, host_sclk_o, host_sclk_oe;
	logic dev_serial_data_line_o, dev_serial_data_line_oe, host_serial_data_line_o, host_serial_data_line_oe;
	logic sclk;
	logic serial_data_line;
	// resolved wires, pulled high when nobody drives
	assign sclk = dev_sclk_oe ? dev_sclk_o :
		(host_sclk_oe ? host_sclk_o : 1'b1);
	assign serial_data_line = dev_serial_data_line_oe ? dev_serial_data_line_o :
		(host_serial_data_line_oe ? host_serial_data_line_o : 1'b1);
	modport device (
		input  mode, standby_n, register_select,
		input  transmit_frame_n, receive_frame_n, sclk, serial_data_line,
		output data_ready_n, dev_sclk_o, dev_sclk_oe,
		output dev_serial_data_line_o, dev_serial_data_line_oe
	);
	modport host (
		output mode, standby_n, register_select,
		output transmit_frame_n, receive_frame_n,
		output host_sclk_o, host_sclk_oe, host_serial_data_line_o, host_serial_data_line_oe,
		input  data_ready_n, sclk, serial_data_line
	);
endinterface : fsp_if

// *** rtl/fsp_pkg.sv ***
// types shared by both ends of the framed serial port
`include "fsp_regs.svh"
package fsp_pkg;
	typedef logic [`FSP_WORD_BITS-1:0] word_t;
	typedef enum logic [1:0] {
		PH_IDLE  = 2'b00,
		PH_WRITE = 2'b01,
		PH_READ  = 2'b10,
		PH_DONE  = 2'b11
	} phase_t;
	typedef struct packed {
		logic   sclk_s1, sclk_s2, sclk_d;
		logic   sd_s1, sd_s2;
		logic   tfs_s1, tfs_s2, rfs_s1, rfs_s2;
		logic   mode_s1, mode_s2, sel_s1, sel_s2;
		logic   stby_s1, stby_s2, pd;
		phase_t phase;
		logic   sel, data_rd;
		word_t  shreg, ctrl, cal, result;
		logic [4:0] cnt;
		logic [3:0] div;
		logic   sclk_o, sclk_oe, serial_data_line_o, serial_data_line_oe, data_ready_n_n;
	} dev_state_t;
	typedef struct packed {
		logic   sclk_s1, sclk_s2, sclk_d;
		logic   sd_s1, sd_s2, data_ready_n_s1, data_ready_n_s2;
		phase_t phase;
		logic   rd, sel, mode, stby_n;
		word_t  shreg, txdata, rxdata;
		logic [4:0] cnt;
		logic [3:0] div;
		logic   sclk_o, sclk_oe, serial_data_line_o, serial_data_line_oe, tfs_n, rfs_n;
		logic   pready, pslverr;
		logic [31:0] prdata;
	} host_state_t;
endpackage : fsp_pkg

// *** rtl/fsp_regs.svh ***
// constants of the framed serial port: offsets, fields, timing
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH
`define FSP_WORD_BITS      24
`define FSP_PCLK_PERIOD_NS 10
`define FSP_SCLK_PERIOD_NS 160
`define FSP_SCLK_HALF_CYC  ((`FSP_SCLK_PERIOD_NS / 2) / `FSP_PCLK_PERIOD_NS)
`define FSP_CTRL_RESET     24'h000000
`define FSP_CTRL_MD_HI     23
`define FSP_CTRL_MD_LO     21
`define FSP_CTRL_EXC1_BIT  14
`define FSP_CTRL_EXC2_BIT  13
`define FSP_CTRL_UNI_BIT   12
`define FSP_OFF_CMD        8'h00
`define FSP_OFF_TXDATA     8'h04
`define FSP_OFF_RXDATA     8'h08
`define FSP_OFF_STATUS     8'h0C
`define FSP_OFF_CFG        8'h10
`define FSP_CMD_START_BIT  0
`define FSP_CMD_READ_BIT   1
`define FSP_CMD_SEL_BIT    2
`define FSP_CFG_MODE_BIT   0
`define FSP_CFG_STBY_BIT   1
`define FSP_CFG_RESET      32'h00000002
`endif

// *** sim/framed_serial_port_adc_tb.sv ***
// self-checking bench: host and converter ends joined by the link
`timescale 1ns/1ps
module framed_serial_port_adc_tb;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [23:0] sample_in;
	logic        sample_valid;
	logic        cal_done;
	logic [23:0] control_word;
	logic [23:0] calib_word;
	logic        exc1;
	logic        exc2;
	logic        powered_down;
	logic [23:0] ctrl2;
	logic [31:0] rdata;
	logic        rerr;
	int          err_count;
	int          samples_checked;

	fsp_if link ();
	fsp_if link2 ();
	fsp_host u_fsp_host (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
	fsp_device u_fsp_device (.pclk(pclk), .presetn(presetn),
		.sample_in(sample_in), .sample_valid(sample_valid),
		.cal_done(cal_done), .control_word(control_word),
		.calib_word(calib_word), .excitation_current_1(exc1),
		.excitation_current_2(exc2), .powered_down(powered_down),
		.link(link));
	// second converter driven by the bench to break framing on purpose
	fsp_device u_fsp_device_2 (.pclk(pclk), .presetn(presetn),
		.sample_in(24'h000000), .sample_valid(1'b0), .cal_done(1'b0),
		.control_word(ctrl2), .calib_word(), .excitation_current_1(),
		.excitation_current_2(), .powered_down(), .link(link2));
	fsp_monitor u_fsp_monitor (.pclk(pclk), .presetn(presetn),
		.mode(link.mode), .standby_n(link.standby_n),
		.register_select(link.register_select),
		.transmit_frame_n(link.transmit_frame_n),
		.receive_frame_n(link.receive_frame_n),
		.data_ready_n(link.data_ready_n), .dev_sclk_oe(link.dev_sclk_oe),
		.dev_serial_data_line_oe(link.dev_serial_data_line_oe), .host_serial_data_line_oe(link.host_serial_data_line_oe),
		.sclk(link.sclk), .serial_data_line(link.serial_data_line));

	always #5 pclk = ~pclk;

	// =====================================================
	// tasks and expectations
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic close_out();
		if (err_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdata = prdata;
		rerr  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic link_op(input logic rd, input logic sel,
		input logic [23:0] d);
		apb(1'b1, 8'h04, {8'h00, d});
		apb(1'b1, 8'h00, {29'h0, sel, rd, 1'b1});
		do begin
			apb(1'b0, 8'h0C, 32'h00000000);
		end while (rdata[0] !== 1'b0);
		repeat (6) @(posedge pclk);
		if (rd)
			apb(1'b0, 8'h08, 32'h00000000);
	endtask : link_op

	task automatic pulse(input logic is_cal, input logic [23:0] s);
		@(posedge pclk);
		sample_in    <= s;
		sample_valid <= !is_cal;
		cal_done     <= is_cal;
		@(posedge pclk);
		sample_valid <= 1'b0;
		cal_done     <= 1'b0;
		while (link.data_ready_n !== 1'b0) begin
			@(posedge pclk);
		end
	endtask : pulse

	function automatic logic [23:0] code_of(input logic [23:0] s,
		input logic uni);
		if (uni)
			return s[23] ? 24'h000000 : {s[22:0], 1'b0};
		return {~s[23], s[22:0]};
	endfunction : code_of

	task automatic send2(input logic fr, input int n, input logic [23:0] d);
		@(posedge pclk);
		link2.transmit_frame_n <= !fr;
		link2.host_sclk_oe     <= 1'b1;
		link2.host_serial_data_line_oe    <= 1'b1;
		link2.host_serial_data_line_o     <= d[23];
		for (int i = 0; i < n; i++) begin
			repeat (8) @(posedge pclk);
			link2.host_sclk_o <= 1'b0;
			if (i > 0 && i < 24)
				link2.host_serial_data_line_o <= d[23 - i];
			repeat (8) @(posedge pclk);
			link2.host_sclk_o <= 1'b1;
		end
		repeat (8) @(posedge pclk);
		link2.transmit_frame_n <= 1'b1;
		link2.host_sclk_oe     <= 1'b0;
		link2.host_serial_data_line_oe    <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask : send2

	// =====================================================
	// main sequence
	initial begin
		logic [31:0] rnd;
		logic [23:0] d;
		logic [23:0] c;
		logic [23:0] s;
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, sample_valid, cal_done} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		sample_in = 24'h000000;
		{link2.mode, link2.register_select, link2.host_sclk_oe} = 3'h0;
		link2.host_serial_data_line_oe = 1'b0;
		{link2.standby_n, link2.transmit_frame_n} = 2'h3;
		{link2.receive_frame_n, link2.host_sclk_o} = 2'h3;
		link2.host_serial_data_line_o = 1'b1;
		err_count = 0;
		samples_checked = 0;
		rnd = $urandom(68);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		chk(control_word, 32'h00000000);
		chk({exc1, exc2, link.data_ready_n}, 32'h00000001);
		apb(1'b0, 8'h10, 32'h00000000);
		chk(rdata, 32'h00000002);
		apb(1'b0, 8'h20, 32'h00000000);
		chk({rerr, rdata[30:0]}, 32'h80000000);
		send2(1'b1, 23, 24'hA5A5A5);
		chk(ctrl2, 32'h00000000);
		send2(1'b0, 24, 24'h5A5A5A);
		chk(ctrl2, 32'h00000000);
		rnd = $urandom();
		send2(1'b1, 26, rnd[23:0]);
		chk(ctrl2, rnd[23:0]);
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, 8'h10, {30'h0, 1'b1, m[0]});
			repeat (4) @(posedge pclk);
			rnd = $urandom();
			d = rnd[23:0] & 24'h1FFFFF;
			link_op(1'b0, 1'b0, d);
			chk(control_word, d);
			chk({exc1, exc2}, {d[14], d[13]});
			link_op(1'b1, 1'b0, 24'h000000);
			chk(rdata, d);
			rnd = $urandom();
			c = rnd[23:0];
			link_op(1'b0, 1'b1, c);
			chk(calib_word, c);
			pulse(1'b1, 24'h000000);
			chk(link.data_ready_n, 1'b0);
			link_op(1'b0, 1'b0, d | 24'h200000);
			link_op(1'b1, 1'b1, 24'h000000);
			chk(rdata, c);
			for (int u = 0; u < 2; u++) begin
				rnd = $urandom();
				s = (m == u) ? 24'h800000 : rnd[23:0];
				link_op(1'b0, 1'b0, (d & 24'h1FEFFF) | {11'h0, u[0], 12'h0});
				pulse(1'b0, s);
				chk(link.data_ready_n, 1'b0);
				apb(1'b0, 8'h0C, 32'h00000000);
				chk(rdata, 32'h00000002);
				link_op(1'b1, 1'b1, 24'h000000);
				chk(rdata, code_of(s, u[0]));
				chk(link.data_ready_n, 1'b1);
			end
			if (m == 0) begin
				link_op(1'b1, 1'b1, 24'h000000);
				chk(rdata, 32'h00FFFFFF);
			end
		end
		pulse(1'b0, rnd[23:0]);
		apb(1'b1, 8'h10, 32'h00000000);
		repeat (8) @(posedge pclk);
		chk({powered_down, link.data_ready_n}, 32'h00000003);
		apb(1'b1, 8'h10, 32'h00000002);
		repeat (8) @(posedge pclk);
		chk(powered_down, 1'b0);
		close_out();
	end

	initial begin
		#900000;
		err_count++;
		close_out();
	end
endmodule : framed_serial_port_adc_tb

// *** sim/fsp_monitor.sv ***
// concurrent checks on the serial link between converter and host
`timescale 1ns/1ps
module fsp_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic mode,
	input wire logic standby_n,
	input wire logic register_select,
	input wire logic transmit_frame_n,
	input wire logic receive_frame_n,
	input wire logic data_ready_n,
	input wire logic dev_sclk_oe,
	input wire logic dev_serial_data_line_oe,
	input wire logic host_serial_data_line_oe,
	input wire logic sclk,
	input wire logic serial_data_line
);
	logic       idle;
	logic [4:0] rise_cnt_r;
	logic       sclk_d_r;
	logic       idle_d_r;

	assign idle = transmit_frame_n && receive_frame_n;

	// =====================================================
	// rising clock edges counted since the last frame start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise_cnt_r <= 5'h00;
			sclk_d_r   <= 1'b1;
			idle_d_r   <= 1'b1;
		end else begin
			sclk_d_r <= sclk;
			idle_d_r <= idle;
			if (idle_d_r && !idle)
				rise_cnt_r <= 5'h00;
			else if (!idle && sclk && !sclk_d_r && rise_cnt_r != 5'h1F)
				rise_cnt_r <= rise_cnt_r + 5'h01;
		end
	end

	// =====================================================
	// properties
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_idle_high;
		sclk [*6] ##[1:4] !sclk;
	endsequence
	sequence s_low_phase;
		(!sclk) [*8] ##1 sclk;
	endsequence

	a_self_clk_start: assert property ($rose(dev_sclk_oe) |->
		mode && !idle) else $error("device clock without frame");
	a_clk_ext_quiet: assert property (dev_sclk_oe |-> mode)
		else $error("device clock in external mode");
	a_clk_release: assert property (idle [*6] |-> !dev_sclk_oe)
		else $error("device clock held after frame");
	a_data_release: assert property (
		receive_frame_n [*6] |-> !dev_serial_data_line_oe)
		else $error("data driven without receive frame");
	a_read_gated: assert property (
		$rose(dev_serial_data_line_oe) && register_select |-> !data_ready_n)
		else $error("result driven while not ready");
	a_ready_word_end: assert property (
		$rose(data_ready_n) && standby_n |-> ##1 rise_cnt_r == 5'h18)
		else $error("ready rose before full word");
	// clock idles high before first fall
	a_first_fall: assert property ($rose(dev_sclk_oe) |->
		s_idle_high) else $error("first clock fall out of place");
	// low phase length of own clock
	a_half_period: assert property (
		dev_sclk_oe && $fell(sclk) |-> s_low_phase)
		else $error("clock low phase wrong");
	a_data_stable: assert property (
		(dev_serial_data_line_oe || host_serial_data_line_oe) && $rose(sclk)
		|-> $stable(serial_data_line))
		else $error("data moved at rising clock");
endmodule : fsp_monitor
